// ==== hw/ippc_ctrl.sv ====
`timescale 1ns/1ns
`include "ippc_regs.svh"
// Function
// - Clear-pending write ones clears; reads pending
// - Clear-pending leaves active state alone
// - Two-bit priority per interrupt, eight words
// - Priority words accessed as full words
// - Four priority fields per word, lanes
// - Interrupt M in word M/4, lane M%4
// - Lower priority value wins selection
// - Only bits 7:6 stored, rest zero
// - Level requester holds line until serviced
// - Lines sampled on clock, pulses latched
// - Pending from level, edge or software
// - ISR entry clears pending, sets active
// - Level return: resample line for pending
// - Pulse during ISR: pending plus active
// - Level clear ignored while line asserted
// - Pulse clear: drop pending, keep active
// - Disabled interrupts may still become pending
// - Software issues aligned accesses only
// - Thirty-two inputs with own state
// - Set/clear enable write ones, read enables
// - Only enabled pending interrupts offered
// - Set-pending write one makes pending
module ippc_ctrl
  import ippc_pkg::*;
#(
  parameter int N = 32
)(
  // Clock and reset
  input wire logic         pclk,
  input wire logic         presetn,
  // APB slave
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Link to core
  ippc_if.ctrl             lnk
);
  logic [N-1:0] enable;
  logic [N-1:0] pending;
  logic [N-1:0] active;
  logic [N-1:0] level_mode;
  ippc_prio_t   prio [0:N-1];
  logic [N-1:0] line;
  logic [N-1:0] line_q;
  logic [N-1:0] next_pending;
  logic [N-1:0] next_active;
  logic         wr;
  logic         rd;
  logic         best_valid;
  ippc_id_t     best_id;
  ippc_prio_t   best_prio;
  logic [31:0]  rword;
  logic         mapped;

  // Access decode; a single-cycle APB answer
  assign wr = psel && penable && pwrite && pready;
  assign rd = psel && !penable && !pwrite;

  ////////////////////////////////////////////////////////////////
  // Lines come from logic on pclk; a filter would swallow one-cycle pulses
  assign line = lnk.irq_line;

  // Previous sampled level for edge detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      line_q <= '0;
    else
      line_q <= line;
  end

  ////////////////////////////////////////////////////////////////
  // Per-interrupt pending/active state
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_irq
      logic hw_set;
      logic sw_clr;
      logic entering;
      logic returning;
      logic next_pend;
      logic next_act;
      assign entering  = lnk.isr_enter && lnk.enter_id == 5'(g);
      assign returning = lnk.isr_return && lnk.return_id == 5'(g);
      assign sw_clr    = wr && paddr == `IPPC_PENDING_CLEAR_OFS && pwdata[g];
      // Level: asserted and not active (entry makes it active); pulse: rising edge
      assign hw_set    = level_mode[g] ? (line[g] && !active[g] && !entering && !returning)
                                       : (line[g] && !line_q[g]);
      always_comb
      begin
        next_pend = pending[g];
        next_act  = active[g];
        if (sw_clr)
        begin
          if (!(level_mode[g] && line[g]))
            next_pend = 1'b0;
          if (level_mode[g] && !line[g] && !pending[g])
            next_act = active[g];
        end
        if (entering)
        begin
          next_pend = 1'b0;
          next_act  = 1'b1;
        end
        if (returning)
        begin
          next_act = 1'b0;
          if (level_mode[g] && line[g])
            next_pend = 1'b1;
        end
        // Sets win over any clear in the same cycle; pulse in ISR too
        if (hw_set || (wr && paddr == `IPPC_PENDING_SET_OFS && pwdata[g]))
          next_pend = 1'b1;
      end
      // One process per bit; vectors gathered by plain assignment
      assign next_pending[g] = next_pend;
      assign next_active[g]  = next_act;
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pending <= '0;
      active  <= '0;
    end
    else
    begin
      pending <= next_pending;
      active  <= next_active;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Enables and level/pulse mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable     <= '0;
      level_mode <= '0;
    end
    else if (wr)
    begin
      if (paddr == `IPPC_ENABLE_SET_OFS)
        enable <= enable | pwdata[N-1:0];
      if (paddr == `IPPC_ENABLE_CLEAR_OFS)
        enable <= enable & ~pwdata[N-1:0];
      if (paddr == `IPPC_LEVEL_MODE_OFS)
        level_mode <= pwdata[N-1:0];
    end
  end

  // Priority fields, only the top two bits of each lane kept
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < N; i++)
        prio[i] <= `IPPC_RESET_PRIO;
    end
    else if (wr && paddr >= `IPPC_PRIORITY_OFS && paddr <= `IPPC_PRIORITY_LAST_OFS &&
             paddr[1:0] == 2'h0)
    begin
      // Word access only; byte strobes are not honoured
      for (int i = 0; i < N; i++)
        if (paddr[4:2] == 3'(i / 4))
          prio[i] <= pwdata[(i % 4) * `IPPC_LANE_BITS + `IPPC_PRIO_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Selection: lowest value first, then lowest number
  always_comb
  begin
    best_valid = 1'b0;
    best_id    = 5'h00;
    best_prio  = 2'h3;
    for (int i = 0; i < N; i++)
      if (pending[i] && enable[i] && !active[i] &&
          (!best_valid || prio[i] < best_prio))
      begin
        best_valid = 1'b1;
        best_id    = 5'(i);
        best_prio  = prio[i];
      end
  end

  // Offer registered; the core side decides preemption
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lnk.take_req  <= 1'b0;
      lnk.take_id   <= 5'h00;
      lnk.take_prio <= 2'h0;
    end
    else
    begin
      lnk.take_req  <= best_valid && !lnk.isr_enter;
      lnk.take_id   <= best_id;
      lnk.take_prio <= best_prio;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read mux; misaligned or unknown addresses give an error
  always_comb
  begin
    rword  = `IPPC_RESET_WORD;
    mapped = 1'b1;
    case (paddr)
      `IPPC_ENABLE_SET_OFS,
      `IPPC_ENABLE_CLEAR_OFS:  rword[N-1:0] = enable;
      `IPPC_PENDING_SET_OFS,
      `IPPC_PENDING_CLEAR_OFS: rword[N-1:0] = pending;
      `IPPC_ACTIVE_OFS:        rword[N-1:0] = active;
      `IPPC_LEVEL_MODE_OFS:    rword[N-1:0] = level_mode;
      `IPPC_CORE_OFS:          rword = {23'h0, best_valid, 3'h0, best_id};
      default:
      begin
        if (paddr >= `IPPC_PRIORITY_OFS && paddr <= `IPPC_PRIORITY_LAST_OFS && paddr[1:0] == 2'h0)
        begin
          for (int k = 0; k < 4; k++)
            rword[k * `IPPC_LANE_BITS + `IPPC_PRIO_LSB +: 2] = prio[{paddr[4:2], 2'(k)}];
        end
        else
          mapped = 1'b0;
      end
    endcase
  end

  // APB: read data captured in setup, answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= `IPPC_RESET_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (rd)
        prdata <= rword;
    end
  end
endmodule

// ==== hw/ippc_regs.svh ====
`ifndef IPPC_REGS_SVH
`define IPPC_REGS_SVH
// Register byte offsets on APB
`define IPPC_ENABLE_SET_OFS    12'h000
`define IPPC_ENABLE_CLEAR_OFS  12'h004
`define IPPC_PENDING_SET_OFS   12'h008
`define IPPC_PENDING_CLEAR_OFS 12'h00C
`define IPPC_ACTIVE_OFS        12'h010
`define IPPC_CORE_OFS          12'h014
`define IPPC_LEVEL_MODE_OFS    12'h018
`define IPPC_PRIORITY_OFS      12'h020
`define IPPC_PRIORITY_LAST_OFS 12'h03C
// Core status fields
`define IPPC_CORE_REQ_BIT      8
`define IPPC_CORE_ID_LSB       0
// Priority field placement within a byte lane
`define IPPC_PRIO_LSB          6
`define IPPC_LANE_BITS         8
// Reset values
`define IPPC_RESET_WORD        32'h0000_0000
`define IPPC_RESET_PRIO        2'h0
`endif

// ==== hw/ippc_pkg.sv ====
package ippc_pkg;
  typedef logic [1:0] ippc_prio_t;
  typedef logic [4:0] ippc_id_t;
  typedef enum logic [1:0] {IPPC_IDLE, IPPC_IN_ISR} ippc_core_state_t;
endpackage

// ==== hw/ippc_if.sv ====
`timescale 1ns/1ns
interface ippc_if #(parameter int N = 32) (input wire logic pclk, input wire logic presetn);
  logic [N-1:0] irq_line;   // peripheral request lines
  logic         take_req;   // controller offers an interrupt
  logic [4:0]   take_id;    // offered interrupt number
  logic [1:0]   take_prio;  // offered priority
  logic         isr_enter;  // core accepts take_id (pulse)
  logic [4:0]   enter_id;   // interrupt entered
  logic         isr_return; // core returns from ISR (pulse)
  logic [4:0]   return_id;  // interrupt returned
  modport ctrl (input irq_line, isr_enter, enter_id, isr_return, return_id,
                output take_req, take_id, take_prio);
  modport core (output isr_enter, enter_id, isr_return, return_id,
                input take_req, take_id, take_prio);
endinterface

// ==== hw/ippc_core_end.sv ====
`timescale 1ns/1ns
`include "ippc_regs.svh"
// Simple processor-side end: takes offered interrupts, runs ISR, returns
module ippc_core_end
  import ippc_pkg::*;
#(
  parameter int ISR_CYCLES = 8
)(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link
  ippc_if.core     lnk,
  // User side
  input wire logic isr_done,
  output logic     in_isr,
  output logic [4:0] cur_id
);
  ippc_core_state_t state;
  logic [4:0]       stack_id [0:3];
  logic [1:0]       stack_prio [0:3];
  logic [2:0]       depth;
  logic [1:0]       cur_prio;

  ////////////////////////////////////////////////////////////////
  // Nesting: only strictly better priority preempts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      depth          <= 3'h0;
      lnk.isr_enter  <= 1'b0;
      lnk.isr_return <= 1'b0;
      lnk.enter_id   <= 5'h00;
      lnk.return_id  <= 5'h00;
      in_isr         <= 1'b0;
      cur_id         <= 5'h00;
      cur_prio       <= 2'h0;
      state          <= IPPC_IDLE;
      for (int i = 0; i < 4; i++)
      begin
        stack_id[i]   <= 5'h00;
        stack_prio[i] <= 2'h0;
      end
    end
    else
    begin
      lnk.isr_enter  <= 1'b0;
      lnk.isr_return <= 1'b0;
      if (lnk.take_req && !lnk.isr_enter && depth < 3'h4 &&
          (depth == 3'h0 || lnk.take_prio < cur_prio))
      begin
        lnk.isr_enter          <= 1'b1;
        lnk.enter_id           <= lnk.take_id;
        stack_id[depth[1:0]]   <= lnk.take_id;
        stack_prio[depth[1:0]] <= lnk.take_prio;
        cur_id                 <= lnk.take_id;
        cur_prio               <= lnk.take_prio;
        depth                  <= depth + 3'h1;
        in_isr                 <= 1'b1;
        state                  <= IPPC_IN_ISR;
      end
      else if (isr_done && depth != 3'h0 && !lnk.isr_enter)
      begin
        lnk.isr_return <= 1'b1;
        lnk.return_id  <= cur_id;
        depth          <= depth - 3'h1;
        if (depth == 3'h1)
        begin
          in_isr <= 1'b0;
          state  <= IPPC_IDLE;
        end
        else
        begin
          cur_id   <= stack_id[depth[1:0] - 2'h2];
          cur_prio <= stack_prio[depth[1:0] - 2'h2];
        end
      end
    end
  end
endmodule

// ==== dv/ippc_chk_sva.sv ====
`timescale 1ns/1ns
module ippc_chk (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Link signals
  input wire logic [31:0] irq_line,
  input wire logic        take_req,
  input wire logic [4:0]  take_id,
  input wire logic [1:0]  take_prio,
  input wire logic        isr_enter,
  input wire logic [4:0]  enter_id,
  input wire logic        isr_return,
  input wire logic [4:0]  return_id
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  int         depth;
  logic [4:0] stk [4];
  logic [1:0] top;
  ////////////////////////////////////////////////////////////
  // Nesting depth, enters minus returns
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      depth <= 0;
    else
      depth <= depth + int'(isr_enter) - int'(isr_return);
  end
  // Entered ids; no reset, depth guards every read
  always_ff @(posedge pclk)
  begin
    if (isr_enter)
      stk[2'(depth - int'(isr_return))] <= enter_id;
  end
  assign top = 2'(depth - 1);
  ////////////////////////////////////////////////////////////
  AST_ENTER_REQ: assert property (isr_enter |-> $past(take_req))
    else $error("entry without an offered interrupt");
  AST_ENTER_ID: assert property (isr_enter |-> enter_id == $past(take_id))
    else $error("entered id differs from offer");
  AST_TAKE_DROP: assert property (isr_enter |=> !take_req)
    else $error("offer kept after entry");
  AST_ENTER_PULSE: assert property (isr_enter |=> !isr_enter)
    else $error("entry longer than one cycle");
  AST_RET_PULSE: assert property (isr_return |=> !isr_return)
    else $error("return longer than one cycle");
  AST_RET_NEEDS: assert property (isr_return |-> depth > 0)
    else $error("return with nothing active");
  AST_DEPTH_MAX: assert property (depth <= 4)
    else $error("nesting too deep");
  AST_RET_LIFO: assert property (isr_return |-> return_id == stk[top])
    else $error("return out of nesting order");
  // Main scenarios
  cover property (isr_enter);
  cover property (isr_return ##[1:20] isr_enter);
  cover property (take_req && take_prio == 2'h0);
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ns
`include "ippc_regs.svh"
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, isr_done, pready, pslverr, in_isr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v, c;
  logic [31:0] m_prio [8];
  logic [4:0]  cur_id;
  int          failures, checks, cyc, seed, best, k;
  ////////////////////////////////////////////////////////////
  ippc_if i_ippc_if (.pclk(pclk), .presetn(presetn));
  ippc_ctrl i_ippc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(i_ippc_if));
  ippc_core_end i_ippc_core_end (.pclk(pclk), .presetn(presetn), .lnk(i_ippc_if), .isr_done(isr_done),
    .in_isr(in_isr), .cur_id(cur_id));
  ippc_chk i_ippc_chk (.pclk(pclk), .presetn(presetn), .irq_line(i_ippc_if.irq_line),
    .take_req(i_ippc_if.take_req), .take_id(i_ippc_if.take_id), .take_prio(i_ippc_if.take_prio),
    .isr_enter(i_ippc_if.isr_enter), .enter_id(i_ippc_if.enter_id), .isr_return(i_ippc_if.isr_return),
    .return_id(i_ippc_if.return_id));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; idle cycle after so psel never toggles twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(rd, e);
  endtask
  // Bounded wait on the core's busy level
  task automatic wt(input logic lvl);
    int n;
    n = 0;
    while (in_isr !== lvl && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    chk(in_isr, lvl);
  endtask
  task automatic pulse(input int i);
    i_ippc_if.irq_line[i] <= 1'b1;
    @(posedge pclk);
    i_ippc_if.irq_line[i] <= 1'b0;
  endtask
  task automatic done();
    isr_done <= 1'b1;
    @(posedge pclk);
    isr_done <= 1'b0;
  endtask
  function automatic int pr(int i);
    return m_prio[i/4][8*(i%4)+6 +: 2];
  endfunction
  task automatic summarize();
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      failures++;
      summarize();
    end
  end
  initial
  begin
    seed = 32'h27931121;
    {psel, penable, pwrite, isr_done, paddr, pwdata, presetn} = '0;
    i_ippc_if.irq_line = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values; 0x1C and 0x40 are holes
    for (int a = 0; a < 68; a += 4)
    begin
      rc(12'(a), 0);
      chk(err, 32'(a == 28 || a == 64));
    end
    // Priority lanes keep only the top two bits
    for (int w = 0; w < 8; w++)
    begin
      v = $random(seed);
      m_prio[w] = v & 32'hC0C0_C0C0;
      wr(12'h020 + 12'(4 * w), v);
      rc(12'h020 + 12'(4 * w), m_prio[w]);
    end
    v = $random(seed);
    c = $random(seed);
    wr(`IPPC_ENABLE_SET_OFS, v);
    wr(`IPPC_ENABLE_CLEAR_OFS, c);
    rc(`IPPC_ENABLE_CLEAR_OFS, v & ~c);
    wr(`IPPC_ENABLE_CLEAR_OFS, '1);
    // Software pending while disabled, never offered
    wr(`IPPC_PENDING_SET_OFS, v);
    rc(`IPPC_PENDING_CLEAR_OFS, v);
    chk(in_isr, 0);
    wr(`IPPC_PENDING_CLEAR_OFS, c);
    apb(1'b1, 12'h00A, '1);
    chk(err, 1);
    rc(`IPPC_PENDING_SET_OFS, v & ~c);
    // All pending: lowest value wins, ties to lowest number
    best = 31;
    for (int i = 31; i >= 0; i--)
      if (pr(i) <= pr(best))
        best = i;
    wr(`IPPC_PENDING_SET_OFS, '1);
    wr(`IPPC_ENABLE_SET_OFS, '1);
    wt(1);
    chk(cur_id, best);
    // Next candidate while best runs: lowest value, then lowest number
    k = (best == 31) ? 30 : 31;
    for (int i = 31; i >= 0; i--)
      if (i != best && pr(i) <= pr(k))
        k = i;
    rc(`IPPC_CORE_OFS, 32'h100 | k);
    rc(`IPPC_ACTIVE_OFS, 32'h1 << best);
    rc(`IPPC_PENDING_SET_OFS, ~(32'h1 << best));
    wr(`IPPC_PENDING_CLEAR_OFS, '1);
    rc(`IPPC_PENDING_SET_OFS, 0);
    rc(`IPPC_ACTIVE_OFS, 32'h1 << best);
    done();
    wt(0);
    rc(`IPPC_ACTIVE_OFS, 0);
    wr(`IPPC_ENABLE_CLEAR_OFS, '1);
    // Level line held over return
    v = $random(seed);
    k = v[4:0];
    wr(`IPPC_LEVEL_MODE_OFS, 32'h1 << k);
    wr(`IPPC_ENABLE_SET_OFS, 32'h1 << k);
    i_ippc_if.irq_line[k] <= 1'b1;
    wt(1);
    chk(cur_id, k);
    rc(`IPPC_PENDING_SET_OFS, 0);
    wr(`IPPC_ENABLE_CLEAR_OFS, 32'h1 << k);
    done();
    wt(0);
    rc(`IPPC_PENDING_SET_OFS, 32'h1 << k);
    wr(`IPPC_PENDING_CLEAR_OFS, 32'h1 << k);
    rc(`IPPC_PENDING_SET_OFS, 32'h1 << k);
    i_ippc_if.irq_line[k] <= 1'b0;
    repeat (6) @(posedge pclk);
    wr(`IPPC_PENDING_CLEAR_OFS, 32'h1 << k);
    rc(`IPPC_PENDING_SET_OFS, 0);
    // Pulse again inside the routine
    wr(`IPPC_LEVEL_MODE_OFS, 0);
    wr(`IPPC_ENABLE_SET_OFS, 32'h1 << k);
    pulse(k);
    wt(1);
    pulse(k);
    repeat (6) @(posedge pclk);
    rc(`IPPC_PENDING_SET_OFS, 32'h1 << k);
    rc(`IPPC_ACTIVE_OFS, 32'h1 << k);
    wr(`IPPC_PENDING_CLEAR_OFS, 32'h1 << k);
    rc(`IPPC_ACTIVE_OFS, 32'h1 << k);
    done();
    wt(0);
    rc(`IPPC_ACTIVE_OFS, 0);
    summarize();
  end
endmodule
